/* verilog/dac_defs.vh */
// Constants for the dual converter output and mode logic
`ifndef DAC_DEFS_VH
`define DAC_DEFS_VH
`define DAC_WORD_W        8
`define DAC_MSB_W         5
`define DAC_FLASH_W       3
`define DAC_PIPE_DEPTH    4
`define DAC_RECOVERY_CYC  15
`define DAC_CNT_W         4
`define DAC_FIFO_DEPTH    32
`define DAC_FIFO_AW       5
`define DAC_MODE_BOTH_SBY 2'b00
`define DAC_MODE_B_SBY    2'b01
`define DAC_MODE_NORMAL   2'b10
`define DAC_MODE_ALIGN    2'b11
`define DAC_SIGN_FLIP     8'h80
`endif

/* verilog/dac_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dac_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             sys_clk_i,  // System clock
  input  wire             rst_n_i,    // Async reset, active low
  input  wire [WIDTH-1:0] in_data_i,  // Write data
  input  wire             in_valid_i, // Write request
  output wire             in_ready_o, // Not full
  output wire [WIDTH-1:0] out_data_o, // Head word
  output wire             out_valid_o,// Not empty
  input  wire             out_ready_i // Drain accepts
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

/* verilog/dac_top.v */
// Output, format and standby logic of a dual 8-bit pipelined sampling converter
`timescale 1ns/1ns
`include "dac_defs.vh"
module dac_top (
  input  wire                   sys_clk_i,         // 20 MHz system clock
  input  wire                   rst_n_i,           // Async reset, active low
  input  wire                   sample_clock_a_i,  // Channel A sample clock pin
  input  wire                   sample_clock_b_i,  // Channel B sample clock pin
  input  wire [`DAC_MSB_W-1:0]  stage_bits_a_i,    // Channel A pipeline MSBs
  input  wire [`DAC_FLASH_W-1:0] flash_bits_a_i,   // Channel A flash bits
  input  wire [`DAC_MSB_W-1:0]  stage_bits_b_i,    // Channel B pipeline MSBs
  input  wire [`DAC_FLASH_W-1:0] flash_bits_b_i,   // Channel B flash bits
  input  wire                   format_select_i,   // High: twos complement
  input  wire                   mode_pin_one_i,    // Mode select, upper bit
  input  wire                   mode_pin_two_i,    // Mode select, lower bit
  output reg  [`DAC_WORD_W-1:0] sample_word_a_o,   // Channel A data
  output reg  [`DAC_WORD_W-1:0] sample_word_a_oe_n_o, // Channel A enables, low drives
  output reg  [`DAC_WORD_W-1:0] sample_word_b_o,   // Channel B data
  output reg  [`DAC_WORD_W-1:0] sample_word_b_oe_n_o, // Channel B enables, low drives
  output reg                    valid_a_o,         // Channel A word past recovery
  output reg                    valid_b_o,         // Channel B word past recovery
  output reg  [`DAC_WORD_W-1:0] stream_data_o,     // Buffered channel A words
  output reg                    stream_valid_o,    // Stream word present
  input  wire                   stream_ready_i,    // Stream sink accepts
  output reg                    overflow_o         // Sticky: word lost, buffer full
);
  localparam W = `DAC_WORD_W;
  localparam D = `DAC_PIPE_DEPTH;

  // Clock, mode and format pins pass two flip-flops; only stage two is read
  reg [1:0]  clk_a_s1_r, clk_a_s2_r;
  reg [1:0]  mode_s1_r,  mode_s2_r;
  reg        fmt_s1_r,   fmt_s2_r;
  reg        clk_a_d_r,  clk_b_d_r;
  wire       rise_a, rise_b;
  wire       sby_a, sby_b, align;
  reg [W-1:0] pipe_a_r [0:D-1];
  reg [W-1:0] pipe_b_r [0:D-1];
  reg [W-1:0] hold_b_r;
  reg [`DAC_CNT_W-1:0] rec_a_r, rec_b_r;
  wire [W-1:0] raw_a, raw_b, fmt_a, fmt_b;
  wire        fifo_in_ready, fifo_out_valid;
  wire [W-1:0] fifo_out_data;
  wire        stream_pop;
  integer     i;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_a_s1_r <= 2'b00;
      clk_a_s2_r <= 2'b00;
      mode_s1_r  <= `DAC_MODE_NORMAL;
      mode_s2_r  <= `DAC_MODE_NORMAL;
      fmt_s1_r   <= 1'b0;
      fmt_s2_r   <= 1'b0;
      clk_a_d_r  <= 1'b0;
      clk_b_d_r  <= 1'b0;
    end else begin
      clk_a_s1_r <= {sample_clock_b_i, sample_clock_a_i};
      clk_a_s2_r <= clk_a_s1_r;
      mode_s1_r  <= {mode_pin_one_i, mode_pin_two_i};
      mode_s2_r  <= mode_s1_r;
      fmt_s1_r   <= format_select_i;
      fmt_s2_r   <= fmt_s1_r;
      clk_a_d_r  <= clk_a_s2_r[0];
      clk_b_d_r  <= clk_a_s2_r[1];
    end
  end

  assign sby_a = (mode_s2_r == `DAC_MODE_BOTH_SBY);
  assign sby_b = sby_a | (mode_s2_r == `DAC_MODE_B_SBY);
  assign align = (mode_s2_r == `DAC_MODE_ALIGN);

  // Clock edges are masked while in standby, as if the clock input floated
  assign rise_a = clk_a_s2_r[0] & ~clk_a_d_r & ~sby_a;
  assign rise_b = clk_a_s2_r[1] & ~clk_b_d_r & ~sby_b;

  // Error-corrected stage bits are concatenated with the flash result
  assign raw_a = {stage_bits_a_i, flash_bits_a_i};
  assign raw_b = {stage_bits_b_i, flash_bits_b_i};

  // Format is applied at the pipeline output so a pin change applies from the next output word
  assign fmt_a = fmt_s2_r ? (pipe_a_r[D-1] ^ `DAC_SIGN_FLIP) : pipe_a_r[D-1];
  assign fmt_b = fmt_s2_r ? (pipe_b_r[D-1] ^ `DAC_SIGN_FLIP) : pipe_b_r[D-1];

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < D; i = i + 1) begin
        pipe_a_r[i] <= {W{1'b0}};
        pipe_b_r[i] <= {W{1'b0}};
      end
    end else begin
      if (rise_a) begin
        pipe_a_r[0] <= raw_a;
        for (i = 1; i < D; i = i + 1) begin
          pipe_a_r[i] <= pipe_a_r[i-1];
        end
      end
      if (rise_b) begin
        pipe_b_r[0] <= raw_b;
        for (i = 1; i < D; i = i + 1) begin
          pipe_b_r[i] <= pipe_b_r[i-1];
        end
      end
    end
  end

  // Recovery counters restart while in standby; the word counts as valid after 15 edges
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rec_a_r <= {`DAC_CNT_W{1'b0}};
      rec_b_r <= {`DAC_CNT_W{1'b0}};
    end else begin
      if (sby_a) begin
        rec_a_r <= {`DAC_CNT_W{1'b0}};
      end else if (rise_a && rec_a_r != `DAC_RECOVERY_CYC) begin
        rec_a_r <= rec_a_r + 1'b1;
      end
      if (sby_b) begin
        rec_b_r <= {`DAC_CNT_W{1'b0}};
      end else if (rise_b && rec_b_r != `DAC_RECOVERY_CYC) begin
        rec_b_r <= rec_b_r + 1'b1;
      end
    end
  end

  // Data and valid registers update one system clock after the detected edge; the enables follow the mode every cycle
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_word_a_o      <= {W{1'b0}};
      sample_word_b_o      <= {W{1'b0}};
      hold_b_r             <= {W{1'b0}};
      sample_word_a_oe_n_o <= {W{1'b1}};
      sample_word_b_oe_n_o <= {W{1'b1}};
      valid_a_o            <= 1'b0;
      valid_b_o            <= 1'b0;
    end else begin
      sample_word_a_oe_n_o <= {W{sby_a}};
      sample_word_b_oe_n_o <= {W{sby_b}};
      if (rise_a) begin
        sample_word_a_o <= fmt_a;
        valid_a_o       <= (rec_a_r == `DAC_RECOVERY_CYC);
      end
      if (rise_b) begin
        hold_b_r <= fmt_b;
      end
      if (align) begin
        // Channel B word is republished on channel A's rising edge
        if (rise_a) begin
          sample_word_b_o <= hold_b_r;
          valid_b_o       <= (rec_b_r == `DAC_RECOVERY_CYC);
        end
      end else if (rise_b) begin
        sample_word_b_o <= fmt_b;
        valid_b_o       <= (rec_b_r == `DAC_RECOVERY_CYC);
      end
      if (sby_b) begin
        valid_b_o <= 1'b0;
      end
      if (sby_a) begin
        valid_a_o <= 1'b0;
      end
    end
  end

  // Valid channel A words are also queued for a stream consumer that may stall
  dac_fifo #(
    .WIDTH (W),
    .DEPTH (`DAC_FIFO_DEPTH),
    .AW    (`DAC_FIFO_AW)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (fmt_a),
    .in_valid_i  (rise_a & (rec_a_r == `DAC_RECOVERY_CYC)),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (stream_pop)
  );

  // Registered skid: load when the output slot is empty or being taken
  assign stream_pop = fifo_out_valid & (~stream_valid_o | stream_ready_i);

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stream_data_o  <= {W{1'b0}};
      stream_valid_o <= 1'b0;
      overflow_o     <= 1'b0;
    end else begin
      if (stream_pop) begin
        stream_data_o  <= fifo_out_data;
        stream_valid_o <= 1'b1;
      end else if (stream_ready_i) begin
        stream_valid_o <= 1'b0;
      end
      // The converter cannot stall, so a full buffer drops the word and flags it
      if (rise_a && rec_a_r == `DAC_RECOVERY_CYC && !fifo_in_ready) begin
        overflow_o <= 1'b1;
      end
    end
  end
endmodule

/* tb/dac_checker.sv */
// Concurrent checks on the dual converter output and mode ports
`timescale 1ns/1ns
`include "dac_defs.vh"
module dac_checker (
  input wire                   sys_clk_i,            // Clock
  input wire                   rst_n_i,              // Reset, active low
  input wire                   sample_clock_a_i,     // Channel A clock pin
  input wire                   format_select_i,      // Format pin
  input wire                   mode_pin_one_i,       // Mode upper bit
  input wire                   mode_pin_two_i,       // Mode lower bit
  input wire [`DAC_WORD_W-1:0] sample_word_a_o,      // Channel A data
  input wire [`DAC_WORD_W-1:0] sample_word_b_o,      // Channel B data
  input wire [`DAC_WORD_W-1:0] sample_word_a_oe_n_o, // Channel A enables
  input wire [`DAC_WORD_W-1:0] sample_word_b_oe_n_o, // Channel B enables
  input wire                   valid_a_o,            // Channel A valid
  input wire                   valid_b_o,            // Channel B valid
  input wire [`DAC_WORD_W-1:0] stream_data_o,        // Stream word
  input wire                   stream_valid_o,       // Stream present
  input wire                   stream_ready_i        // Stream accepted
);
  wire [1:0] mode = {mode_pin_one_i, mode_pin_two_i};
  reg  [2:0] clk_a_r;
  reg  [5:0] fmt_r;
  // Same two-flop view of the pin as the block, so a detected rise lines up
  wire       rise_a = clk_a_r[1] & ~clk_a_r[2];
  wire       fmt_calm = (fmt_r == 6'h00) || (fmt_r == 6'h3f);
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_a_r <= 3'h0;
      fmt_r   <= 6'h00;
    end else begin
      clk_a_r <= {clk_a_r[1:0], sample_clock_a_i};
      fmt_r   <= {fmt_r[4:0], format_select_i};
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  oe_off_a: assert property ((mode == 2'b00)[*6] |-> sample_word_a_oe_n_o == 8'hff)
    else $error("channel A drives in standby");
  oe_off_b: assert property ((mode[1] == 1'b0)[*6] |-> sample_word_b_oe_n_o == 8'hff)
    else $error("channel B drives in standby");
  oe_on_a: assert property ((mode != 2'b00)[*6] |-> sample_word_a_oe_n_o == 8'h00)
    else $error("channel A released outside standby");
  oe_on_b: assert property ((mode[1] == 1'b1)[*6] |-> sample_word_b_oe_n_o == 8'h00)
    else $error("channel B released in active mode");
  word_edge_a: assert property ($changed(sample_word_a_o) && fmt_calm |-> $past(rise_a))
    else $error("channel A word moved without a clock rise");
  hold_a_a: assert property ((mode == 2'b00)[*6] |=> $stable(sample_word_a_o))
    else $error("channel A updated in standby");
  hold_b_a: assert property ((mode[1] == 1'b0)[*6] |=> $stable(sample_word_b_o))
    else $error("channel B updated in standby");
  valid_gap_a: assert property ((mode == 2'b00)[*6] |-> !valid_a_o && !valid_b_o)
    else $error("valid high in standby");
  valid_rise_a: assert property ($rose(valid_a_o) |-> $past(rise_a))
    else $error("valid rose off a clock rise");
  align_edge_a: assert property ((mode == 2'b11)[*6] ##0 ($changed(sample_word_b_o) && fmt_calm)
    |-> $past(rise_a))
    else $error("aligned channel B moved off a channel A rise");
  stream_hold_a: assert property (stream_valid_o && !stream_ready_i
    |=> stream_valid_o && $stable(stream_data_o))
    else $error("stream word dropped while stalled");
endmodule
bind dac_top dac_checker u_chk (.sys_clk_i, .rst_n_i, .sample_clock_a_i, .format_select_i, .mode_pin_one_i,
  .mode_pin_two_i, .sample_word_a_o, .sample_word_b_o, .sample_word_a_oe_n_o, .sample_word_b_oe_n_o,
  .valid_a_o, .valid_b_o, .stream_data_o, .stream_valid_o, .stream_ready_i);

/* tb/dac_sink.sv */
// Capture-side model: latches settled channel A words and drains the stream
`timescale 1ns/1ns
module dac_sink (
  input  wire        sys_clk_i,      // Clock
  input  wire        rst_n_i,        // Reset, active low
  input  wire [7:0]  word_a_i,       // Channel A data lines
  input  wire        valid_a_i,      // Channel A past recovery
  input  wire        stream_valid_i, // Stream word present
  input  wire        stall_i,        // Hold off the stream
  output wire        stream_ready_o, // Sink accepts
  output reg  [7:0]  capt_o,         // Last settled word
  output reg  [15:0] count_o         // Stream words taken
);
  reg slow_r;
  // Accepts on alternate cycles only, so the source meets back-pressure even unstalled
  assign stream_ready_o = ~stall_i & slow_r;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_r  <= 1'b0;
      capt_o  <= 8'h00;
      count_o <= 16'h0000;
    end else begin
      slow_r <= ~slow_r;
      if (valid_a_i) begin
        capt_o <= word_a_i;
      end
      if (stream_valid_i && stream_ready_o) begin
        count_o <= count_o + 16'h0001;
      end
    end
  end
endmodule

/* tb/dac_top_tb.sv */
// Self-checking bench for the dual converter output and mode logic
`timescale 1ns/1ns
`include "dac_defs.vh"
module dac_top_tb;
  reg         sys_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         clk_a = 1'b0;
  reg         clk_b = 1'b0;
  reg  [7:0]  wa = 8'h00;
  reg  [7:0]  wb = 8'h00;
  reg         fmt = 1'b0;
  reg  [1:0]  mode = 2'b10;
  reg         stall = 1'b0;
  wire [7:0]  out_a, out_b, oe_a, oe_b, s_data, capt;
  wire        val_a, val_b, s_valid, s_ready, ovf;
  wire [15:0] cnt;
  reg  [15:0] cnt0;
  reg  [7:0]  held;
  integer     fails = 0;
  integer     compares = 0;
  integer     cycles = 0;
  integer     k;
  dac_top u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sample_clock_a_i(clk_a), .sample_clock_b_i(clk_b),
    .stage_bits_a_i(wa[7:3]), .flash_bits_a_i(wa[2:0]), .stage_bits_b_i(wb[7:3]), .flash_bits_b_i(wb[2:0]),
    .format_select_i(fmt), .mode_pin_one_i(mode[1]), .mode_pin_two_i(mode[0]), .sample_word_a_o(out_a),
    .sample_word_a_oe_n_o(oe_a), .sample_word_b_o(out_b), .sample_word_b_oe_n_o(oe_b), .valid_a_o(val_a),
    .valid_b_o(val_b), .stream_data_o(s_data), .stream_valid_o(s_valid), .stream_ready_i(s_ready),
    .overflow_o(ovf));
  dac_sink u_sink (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .word_a_i(out_a), .valid_a_i(val_a),
    .stream_valid_i(s_valid), .stall_i(stall), .stream_ready_o(s_ready), .capt_o(capt), .count_o(cnt));
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (cycles > 20000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function [7:0] cod(input [7:0] w);
    cod = fmt ? (w ^ `DAC_SIGN_FLIP) : w;
  endfunction
  function [7:0] pat(input integer n, input [7:0] s);
    pat = s + 8'h13 * n[7:0];
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask
  // Eight system cycles per sample, 2.5 MSPS, with bits held across the detected rise
  task pulse(input ea, input eb, input [7:0] a, input [7:0] b);
    wa = a;
    wb = b;
    clk_a = ea;
    clk_b = eb;
    cyc(4);
    clk_a = 1'b0;
    clk_b = 1'b0;
    cyc(4);
  endtask
  task sc_latency(input f, input [1:0] m);
    fmt = f;
    mode = m;
    cyc(8);
    for (k = 0; k < 12; k = k + 1) begin
      pulse(1'b1, 1'b1, pat(k, 8'h05), pat(k, 8'h9a));
      // The word shown after edge k was taken four detected edges earlier
      if (k >= 4) chk(out_a, cod(pat(k - 4, 8'h05)));
      if (k >= 4 && m == 2'b10) chk(out_b, cod(pat(k - 4, 8'h9a)));
    end
    if (m == 2'b01) chk({oe_a, oe_b}, 16'h00ff);
  endtask
  task sc_standby;
    mode = 2'b00;
    cyc(8);
    held = out_a;
    cnt0 = {8'h00, capt};
    chk({oe_a, oe_b}, 16'hffff);
    pulse(1'b1, 1'b1, 8'h3c, 8'h3c);
    pulse(1'b1, 1'b1, 8'h3d, 8'h3d);
    chk(out_a, held);
    chk({val_a, val_b}, 2'b00);
    mode = 2'b10;
    cyc(8);
    // Fifteen recovery edges pass before the sixteenth word is marked valid
    for (k = 0; k < 16; k = k + 1) begin
      pulse(1'b1, 1'b1, pat(k, 8'h21), pat(k, 8'h44));
      chk(val_a, k >= 15);
      if (k == 14) chk(capt, cnt0);
    end
  endtask
  task sc_align;
    mode = 2'b11;
    cyc(8);
    held = out_b;
    // Five B edges bring the first new B sample through its four-edge latency
    for (k = 0; k < 5; k = k + 1) pulse(1'b0, 1'b1, 8'h00, pat(k, 8'h61));
    chk(out_b, held);
    pulse(1'b1, 1'b0, 8'h00, 8'h00);
    chk(out_b, cod(pat(0, 8'h61)));
  endtask
  task sc_buffer;
    mode = 2'b10;
    stall = 1'b1;
    cyc(8);
    cnt0 = cnt;
    for (k = 0; k < 40; k = k + 1) pulse(1'b1, 1'b0, pat(k, 8'h50), 8'h00);
    chk({ovf, s_valid}, 2'b11);
    // The stalled slot holds the first word queued here, sample 13 of the recovery run
    chk(s_data, cod(pat(13, 8'h21)));
    stall = 1'b0;
    cyc(120);
    chk({s_valid, cnt - cnt0 >= 16'd32}, 2'b01);
  endtask
  initial begin
    cyc(3);
    rst_n_i = 1'b1;
    cyc(2);
    sc_latency(1'b0, 2'b10);
    sc_latency(1'b1, 2'b10);
    sc_latency(1'b0, 2'b01);
    sc_standby;
    sc_align;
    sc_buffer;
    stop_test;
  end
endmodule
